// ### scbl_device.sv
`timescale 1ns/1ps
// Functional notes
// - copy cells 108..122 on reset when keyed
// - host writes release code to cell 123
// - image occupies 0x16C..0x17B, key last
// - refresh live config from image hourly
// - zero cell 108 disables hourly refresh
// - watchdog reset after 13 s reloads
// - host disables post processing, watchdog first
// - preprogrammed part starts measuring at power-on
// - time-of-flight rate in byte B3, cell 116
// - host writes rate unless it equals one
// - first-hit levels from cells 93, 107
// - checksums held in cells 124..127
// - general pins five, six reserved
// - compute data-memory checksum for cell 101 compare; code checksum (cell 100) not computed
module scbl_device #(
   parameter longint REFRESH_CYCLES = scbl_pkg::REFRESH_CYC,
   parameter longint WDOG_CYCLES = scbl_pkg::WDOG_CYC
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   scbl_if.device fwd,
   input wire logic post_proc_en_in, // firmware operation enable
   input wire logic wdog_en_in,
   input wire logic wdog_kick_in, // watchdog service pulse
   input wire logic [scbl_pkg::CELL_W-1:0] ext_cfg_data_in, // external live-config write
   input wire logic [3:0] ext_cfg_idx_in,
   input wire logic ext_cfg_we_in,
   output logic [scbl_pkg::NUM_CFG*scbl_pkg::CELL_W-1:0] live_cfg_out,
   output logic [7:0] tof_rate_out,
   output logic [31:0] fhl_a_out,
   output logic [31:0] fhl_b_out,
   output logic [31:0] fw_config_out,
   output logic [31:0] amp_min_out,
   output logic [31:0] cksum_data_out,
   output logic cksum_ok_out,
   output logic measure_run_out,
   output logic loading_out,
   output logic wdog_reset_out,
   output logic [scbl_pkg::GP_W-1:0] gp_user_mask_out
);
   import scbl_pkg::*;

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CHECK = 2'b01, ST_COPY = 2'b11, ST_RUN = 2'b10} scbl_state_e;

   logic [31:0] mem_q [0:127]; // firmware-data cells 0..127
   logic [31:0] live_q [0:NUM_CFG-1];
   scbl_state_e state_q, state_d;
   logic [3:0] idx_q;
   logic [63:0] refresh_cnt_q;
   logic [63:0] wdog_cnt_q;
   logic wdog_rst_q;
   logic [31:0] rd_data_q;
   logic rd_done_q;
   logic [31:0] ck_q;
   logic [6:0] ck_idx_q;
   logic [31:0] ck_res_q;

   wire soft_reset = fwd.sys_reset | wdog_rst_q;
   wire key_ok = (mem_q[KEY_CELL[6:0]] == RELEASE_CODE);
   wire refresh_en = (mem_q[CFG_FIRST[6:0]] != 32'h0000_0000);
   wire refresh_due = post_proc_en_in && refresh_en && (refresh_cnt_q >= REFRESH_CYCLES - 64'd1);
   wire wr_ok = fwd.wr_valid && (state_q != ST_COPY); // no writes during copy keeps image coherent
   wire [6:0] cfg_cell = 7'(CFG_FIRST[6:0] + 7'(idx_q));

   assign fwd.wr_ready = (state_q != ST_COPY);
   assign fwd.rd_data = rd_data_q;
   assign fwd.rd_done = rd_done_q;

   // firmware-data store; host writes land here
   always_ff @(posedge clock_in) begin
      if (wr_ok) begin
         mem_q[fwd.wr_addr[6:0]] <= fwd.wr_data;
      end
   end

   // registered read answer
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         rd_data_q <= 32'h0000_0000;
         rd_done_q <= 1'b0;
      end else begin
         rd_done_q <= fwd.rd_valid;
         rd_data_q <= fwd.rd_valid ? mem_q[fwd.rd_addr[6:0]] : rd_data_q;
      end
   end

   // loader state machine
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: state_d = ST_CHECK;
         // an unprogrammed key cell reads unknown and must fall to the default path,
         // so the test is an if and not a select that would merge both states
         ST_CHECK: begin
            if (key_ok) begin
               state_d = ST_COPY;
            end else begin
               state_d = ST_RUN;
            end
         end
         ST_COPY: state_d = (idx_q == 4'(NUM_CFG - 1)) ? ST_RUN : ST_COPY;
         // resets reach idle directly through soft_reset; only the refresh leaves from here
         ST_RUN: begin
            if (refresh_due) begin
               state_d = ST_CHECK;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         state_q <= ST_IDLE;
         idx_q <= 4'h0;
      end else begin
         state_q <= soft_reset ? ST_IDLE : state_d;
         idx_q <= (state_q == ST_COPY) ? 4'(idx_q + 4'h1) : 4'h0;
      end
   end

   // live configuration: defaults on reset, image copy, or external load
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < NUM_CFG; i++) live_q[i] <= CFG_RESET_VAL;
      end else if (state_q == ST_COPY) begin
         live_q[idx_q] <= mem_q[cfg_cell];
      end else if (ext_cfg_we_in && ext_cfg_idx_in < 4'(NUM_CFG)) begin
         live_q[ext_cfg_idx_in] <= ext_cfg_data_in; // overwritten at next refresh
      end
   end

   generate
      for (genvar g = 0; g < NUM_CFG; g++) begin : g_live
         assign live_cfg_out[g*CELL_W +: CELL_W] = live_q[g];
      end
   endgenerate

   // hourly refresh counter, only while firmware runs
   always_ff @(posedge clock_in) begin
      if (!rstn_in || state_q != ST_RUN || !post_proc_en_in) begin
         refresh_cnt_q <= 64'd0;
      end else begin
         refresh_cnt_q <= refresh_cnt_q + 64'd1;
      end
   end

   // watchdog; a timeout pulses a reset that reruns the loader
   always_ff @(posedge clock_in) begin
      if (!rstn_in || !wdog_en_in || wdog_kick_in || wdog_rst_q) begin
         wdog_cnt_q <= 64'd0;
         wdog_rst_q <= 1'b0;
      end else begin
         wdog_cnt_q <= wdog_cnt_q + 64'd1;
         wdog_rst_q <= (wdog_cnt_q >= WDOG_CYCLES - 64'd2);
      end
   end

   // running checksum over firmware-data cells; code memory lives outside this block
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         ck_q <= 32'h0000_0000;
         ck_idx_q <= 7'h00;
         ck_res_q <= 32'h0000_0000;
      end else begin
         ck_idx_q <= 7'(ck_idx_q + 7'h01);
         if (ck_idx_q == 7'h7f) begin
            ck_res_q <= ck_q ^ mem_q[ck_idx_q];
            ck_q <= 32'h0000_0000;
         end else begin
            ck_q <= ck_q ^ mem_q[ck_idx_q];
         end
      end
   end

   // rate byte of the live processing word; word 8 is cell 116, the 4-bit index wraps on purpose
   // a zero byte is an image the host left untouched, which stands for the default rate of one
   wire [7:0] tof_byte = live_q[USM_PRC_CELL[3:0] - 4'(CFG_FIRST[3:0])][TOF_BYTE_LSB +: 8];

   // registered outputs taken from fixed cells, the live rate byte and the loader state
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         tof_rate_out <= TOF_RATE_DEFAULT;
         fhl_a_out <= 32'h0000_0000;
         fhl_b_out <= 32'h0000_0000;
         fw_config_out <= 32'h0000_0000;
         amp_min_out <= 32'h0000_0000;
         measure_run_out <= 1'b0;
      end else begin
         tof_rate_out <= (tof_byte == 8'h00) ? TOF_RATE_DEFAULT : tof_byte;
         fhl_a_out <= mem_q[FHL_CELL_A[6:0]];
         fhl_b_out <= mem_q[FHL_CELL_B[6:0]];
         fw_config_out <= mem_q[FWCFG_CELL[6:0]];
         amp_min_out <= mem_q[AMP_MIN_ADDR[8:2]];
         measure_run_out <= (state_q == ST_RUN);
      end
   end

   assign cksum_data_out = ck_res_q;
   assign cksum_ok_out = (ck_res_q == mem_q[CKREF_DATA[6:0]]);
   assign loading_out = (state_q == ST_COPY);
   assign wdog_reset_out = wdog_rst_q;
   assign gp_user_mask_out = ~((GP_W'(1) << GP_FIVE) | (GP_W'(1) << GP_SIX));
endmodule : scbl_device

// ### scbl_pkg.sv
package scbl_pkg;
   // firmware-data cell map (word indices and byte addresses of one 32-bit cell each)
   localparam int CELL_W = 32;
   localparam int ADDR_W = 9;
   localparam logic [8:0] FHL_CELL_A = 9'h05d; // first-hit level cell 93
   localparam logic [8:0] CKREF_CODE = 9'h064; // reference checksum, code memory, cell 100
   localparam logic [8:0] CKREF_DATA = 9'h065; // reference checksum, data memory, cell 101
   localparam logic [8:0] FWCFG_CELL = 9'h06a; // firmware_operation_config, cell 106
   localparam logic [8:0] FHL_CELL_B = 9'h06b; // first-hit level cell 107
   localparam logic [8:0] CFG_FIRST = 9'h06c; // first stored configuration cell 108
   localparam logic [8:0] CFG_LAST = 9'h07a; // last stored configuration cell 122
   localparam logic [8:0] USM_PRC_CELL = 9'h074; // stored_ultrasonic_processing, cell 116
   localparam logic [8:0] KEY_CELL = 9'h07b; // release-key cell 123
   localparam logic [8:0] CKSUM_FIRST = 9'h07c; // integrity checksums cells 124..127
   localparam logic [8:0] CKSUM_LAST = 9'h07f;
   localparam logic [8:0] AMP_MIN_ADDR = 9'h155; // low_amplitude_limit byte address
   localparam logic [8:0] FWCFG_ADDR = 9'h16a; // firmware_operation_config byte address
   localparam logic [8:0] IMG_ADDR_FIRST = 9'h16c; // stored image start
   localparam logic [8:0] IMG_ADDR_LAST = 9'h17b; // stored image end (release key)
   localparam logic [8:0] CK_ADDR_FIRST = 9'h17c;
   localparam logic [8:0] CK_ADDR_LAST = 9'h17f;
   localparam int NUM_CFG = 15; // cells 108..122
   localparam logic [31:0] RELEASE_CODE = 32'habcd_7654;
   localparam int TOF_BYTE_LSB = 24; // byte B3 of the processing cell
   localparam logic [7:0] TOF_RATE_DEFAULT = 8'h01;
   localparam logic [31:0] CFG_RESET_VAL = 32'h0000_0000;
   // timing
   localparam longint CLK_HZ = 64'd20_000_000;
   localparam longint REFRESH_S = 64'd3600; // refresh at least every hour
   localparam longint WDOG_S = 64'd13; // watchdog typical timeout
   localparam longint REFRESH_CYC = REFRESH_S * CLK_HZ; // longest time, exact
   localparam longint WDOG_CYC = WDOG_S * CLK_HZ;
   localparam int GP_FIVE = 5;
   localparam int GP_SIX = 6;
   localparam int GP_W = 8;
endpackage : scbl_pkg

// ### scbl_if.sv
`timescale 1ns/1ps
// firmware-data access port between host and loader; host writes, device reads its own copy
interface scbl_if;
   logic wr_valid; // host write strobe, held until wr_ready
   logic [8:0] wr_addr; // cell index 0..127
   logic [31:0] wr_data;
   logic wr_ready; // device can take a write
   logic rd_valid; // host read strobe
   logic [8:0] rd_addr;
   logic [31:0] rd_data; // registered answer
   logic rd_done; // one cycle after rd_valid
   logic sys_reset; // host-requested system reset pulse
   modport device (input wr_valid, input wr_addr, input wr_data, output wr_ready,
                   input rd_valid, input rd_addr, output rd_data, output rd_done, input sys_reset);
   modport host (output wr_valid, output wr_addr, output wr_data, input wr_ready,
                 output rd_valid, output rd_addr, input rd_data, input rd_done, output sys_reset);
endinterface : scbl_if

// ### scbl_host.sv
`timescale 1ns/1ps
// host end: writes the image, arms the key, asks for reset
module scbl_host (
   input wire logic clock_in,
   input wire logic rstn_in,
   scbl_if.host fwd,
   input wire logic wr_req_in, // user write request pulse
   input wire logic [8:0] wr_addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic set_tof_in, // write rate byte into cell 116
   input wire logic [7:0] tof_rate_in,
   input wire logic [31:0] usm_prc_base_in,
   input wire logic arm_in, // write release code
   input wire logic reset_req_in,
   input wire logic rd_req_in,
   input wire logic [8:0] rd_addr_in,
   input wire logic temp_cfg_in, // about to load temporary config
   output logic [31:0] rd_data_out,
   output logic rd_done_out,
   output logic busy_out,
   output logic post_proc_en_out,
   output logic wdog_en_out
);
   import scbl_pkg::*;

   logic wr_valid_q;
   logic [8:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic [31:0] rd_data_q;
   logic rd_done_q;
   logic pp_q;

   wire tof_word_needed = set_tof_in && (tof_rate_in != TOF_RATE_DEFAULT);
   wire [31:0] tof_word = {tof_rate_in, usm_prc_base_in[TOF_BYTE_LSB-1:0]};

   assign fwd.wr_valid = wr_valid_q;
   assign fwd.wr_addr = wr_addr_q;
   assign fwd.wr_data = wr_data_q;
   assign fwd.rd_valid = rd_req_in;
   assign fwd.rd_addr = rd_addr_in;
   assign fwd.sys_reset = reset_req_in;
   assign busy_out = wr_valid_q && !fwd.wr_ready;

   // one write held until the device takes it; priority arm, rate, user
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         wr_valid_q <= 1'b0;
         wr_addr_q <= 9'h000;
         wr_data_q <= 32'h0000_0000;
      end else if (!wr_valid_q || fwd.wr_ready) begin
         wr_valid_q <= arm_in || tof_word_needed || wr_req_in;
         if (arm_in) begin
            wr_addr_q <= KEY_CELL;
            wr_data_q <= RELEASE_CODE;
         end else if (tof_word_needed) begin
            wr_addr_q <= USM_PRC_CELL;
            wr_data_q <= tof_word;
         end else begin
            wr_addr_q <= wr_addr_in;
            wr_data_q <= wr_data_in;
         end
      end
   end

   // temporary config keeps: firmware and watchdog off first
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         pp_q <= 1'b1;
         rd_data_q <= 32'h0000_0000;
         rd_done_q <= 1'b0;
      end else begin
         pp_q <= !temp_cfg_in;
         rd_done_q <= fwd.rd_done;
         rd_data_q <= fwd.rd_done ? fwd.rd_data : rd_data_q;
      end
   end

   assign post_proc_en_out = pp_q;
   assign wdog_en_out = pp_q;
   assign rd_data_out = rd_data_q;
   assign rd_done_out = rd_done_q;
endmodule : scbl_host

// ### scbl_properties.sv
`timescale 1ns/1ps
// watches the firmware-data port and the loader outputs between the two ends
module scbl_properties
   import scbl_pkg::*;
(
   input logic clock_in,
   input logic rstn_in,
   input logic wr_valid,
   input logic [8:0] wr_addr,
   input logic [31:0] wr_data,
   input logic wr_ready,
   input logic rd_valid,
   input logic [31:0] rd_data,
   input logic rd_done,
   input logic loading_out,
   input logic measure_run_out,
   input logic wdog_reset_out,
   input logic [GP_W-1:0] gp_user_mask_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rstn_in);
   // a copy moves fifteen cells, one per cycle, and then stops
   property p_copy_len;
      $rose(loading_out) |-> loading_out [*8] ##1 loading_out [*7] ##1 !loading_out;
   endproperty
   a_copy_len: assert property (p_copy_len) else $error("copy length wrong");
   property p_copy_refuses;
      loading_out |-> !wr_ready;
   endproperty
   a_copy_refuses: assert property (p_copy_refuses) else $error("write accepted during copy");
   property p_run_after_reset;
      $rose(rstn_in) |-> ##[1:24] measure_run_out;
   endproperty
   a_run_after_reset: assert property (p_run_after_reset) else $error("measurement did not start");
   property p_gp_reserved;
      gp_user_mask_out[GP_FIVE] == 1'b0 && gp_user_mask_out[GP_SIX] == 1'b0;
   endproperty
   a_gp_reserved: assert property (p_gp_reserved) else $error("reserved pin offered to user");
   property p_wdog_reload;
      wdog_reset_out |-> ##[1:4] loading_out;
   endproperty
   a_wdog_reload: assert property (p_wdog_reload) else $error("watchdog reset did not reload");
   property p_rd_answer;
      rd_valid |=> rd_done;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
   // read data must stay put between answers, the host may sample it late
   property p_rd_hold;
      !rd_done |-> $stable(rd_data);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
   property p_wr_hold;
      wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("refused write not held");
   cv_copy: cover property ($rose(loading_out));
   cv_wdog: cover property (wdog_reset_out);
   cv_read: cover property (rd_done);
endmodule : scbl_properties

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import scbl_pkg::*;
   localparam longint RC = 200; // shortened hourly refresh
   localparam longint WC = 50; // shortened watchdog timeout
   int err_total = 0;
   int num_checks = 0;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic wr_req = 1'b0, set_tof = 1'b0, arm = 1'b0, reset_req = 1'b0, rd_req = 1'b0;
   logic temp_cfg = 1'b1, kick_en = 1'b0, wdog_kick = 1'b0, ext_we = 1'b0;
   logic [8:0] wr_addr = 9'h000, rd_addr = 9'h000;
   logic [31:0] wr_data = 32'h0000_0000, ext_data = 32'h0000_0000, host_rd, fhl_a, fhl_b, fw_cfg, amp_min;
   logic [3:0] ext_idx = 4'h0;
   logic [NUM_CFG*CELL_W-1:0] live_cfg;
   logic [7:0] tof_rate;
   logic [7:0] tof_rate_req = 8'h14;
   logic [31:0] cksum;
   logic cksum_ok;
   logic [GP_W-1:0] gp_mask;
   logic rd_done, busy, pp_en, wd_en, measure_run, loading, wdog_reset;
   scbl_if scbl_if_i ();
   // clock at 20 MHz
   initial begin
      forever #25 clock_in = ~clock_in;
   end
   // kicking on every other edge keeps the watchdog quiet while kick_en is set
   always @(posedge clock_in) begin
      wdog_kick <= kick_en & ~wdog_kick;
   end
   scbl_device #(.REFRESH_CYCLES(RC), .WDOG_CYCLES(WC)) scbl_device_i (
      .clock_in(clock_in), .rstn_in(rstn_in), .fwd(scbl_if_i.device), .post_proc_en_in(pp_en),
      .wdog_en_in(wd_en), .wdog_kick_in(wdog_kick), .ext_cfg_data_in(ext_data), .ext_cfg_idx_in(ext_idx),
      .ext_cfg_we_in(ext_we), .live_cfg_out(live_cfg), .tof_rate_out(tof_rate), .fhl_a_out(fhl_a),
      .fhl_b_out(fhl_b), .fw_config_out(fw_cfg), .amp_min_out(amp_min), .cksum_data_out(cksum),
      .cksum_ok_out(cksum_ok),
      .measure_run_out(measure_run), .loading_out(loading), .wdog_reset_out(wdog_reset), .gp_user_mask_out(gp_mask));
   scbl_host scbl_host_i (
      .clock_in(clock_in), .rstn_in(rstn_in), .fwd(scbl_if_i.host), .wr_req_in(wr_req), .wr_addr_in(wr_addr),
      .wr_data_in(wr_data), .set_tof_in(set_tof), .tof_rate_in(tof_rate_req), .usm_prc_base_in(32'h0000_2824),
      .arm_in(arm), .reset_req_in(reset_req), .rd_req_in(rd_req), .rd_addr_in(rd_addr), .temp_cfg_in(temp_cfg),
      .rd_data_out(host_rd), .rd_done_out(rd_done), .busy_out(busy), .post_proc_en_out(pp_en), .wdog_en_out(wd_en));
   scbl_properties scbl_properties_i (
      .clock_in(clock_in), .rstn_in(rstn_in), .wr_valid(scbl_if_i.wr_valid), .wr_addr(scbl_if_i.wr_addr),
      .wr_data(scbl_if_i.wr_data), .wr_ready(scbl_if_i.wr_ready), .rd_valid(scbl_if_i.rd_valid),
      .rd_data(scbl_if_i.rd_data), .rd_done(scbl_if_i.rd_done), .loading_out(loading),
      .measure_run_out(measure_run), .wdog_reset_out(wdog_reset), .gp_user_mask_out(gp_mask));
   // bookkeeping: compare, bounded-wait failure, verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tmo(input logic bad);
      if (bad) begin
         err_total++;
         $display("ERROR %0t wait ran out", $time);
         results();
      end
   endtask : tmo
   task automatic results();
      if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask : tick
   // image word expected in the live registers; cell 116 carries the rate in its top byte
   function automatic logic [31:0] exp_word(input int i);
      return (i == int'(USM_PRC_CELL - CFG_FIRST)) ? 32'h1400_2824 : 32'h5a00_0100 + 32'(i);
   endfunction : exp_word
   // host command: 0 plain write, 1 rate byte, 2 release key; waits until the host is idle
   task automatic hw(input int m, input logic [8:0] a, input logic [31:0] d);
      tick(1);
      wr_addr <= a;
      wr_data <= d;
      wr_req <= (m == 0);
      set_tof <= (m == 1);
      arm <= (m == 2);
      tick(1);
      wr_req <= 1'b0;
      set_tof <= 1'b0;
      arm <= 1'b0;
      @(negedge clock_in);
      for (int i = 0; i < 50 && busy !== 1'b0; i++) @(negedge clock_in);
      tmo(busy !== 1'b0);
   endtask : hw
   task automatic ext(input int w, input logic [31:0] d);
      tick(1);
      ext_idx <= 4'(w);
      ext_data <= d;
      ext_we <= 1'b1;
      tick(1);
      ext_we <= 1'b0;
      tick(1);
      @(negedge clock_in);
      chk(live_cfg[w*CELL_W +: CELL_W], d);
   endtask : ext
   // the walk fixes a reload at seventeen cycles; 24 leaves margin for the request path
   task automatic sysrst();
      tick(1);
      reset_req <= 1'b1;
      tick(1);
      reset_req <= 1'b0;
      tick(24);
      @(negedge clock_in);
   endtask : sysrst
   task automatic wait_word(input int w, input int lim);
      for (int i = 0; i < lim && live_cfg[w*CELL_W +: CELL_W] !== exp_word(w); i++) @(negedge clock_in);
      chk(live_cfg[w*CELL_W +: CELL_W], exp_word(w));
   endtask : wait_word
   // host read through both registered stages; rd_done_out stands one cycle
   task automatic hr(input logic [8:0] a, input logic [31:0] exp);
      tick(1);
      rd_addr <= a;
      rd_req <= 1'b1;
      tick(1);
      rd_req <= 1'b0;
      for (int i = 0; i < 8 && rd_done !== 1'b1; i++) @(negedge clock_in);
      tmo(rd_done !== 1'b1);
      chk(host_rd, exp);
   endtask : hr
   // a copy in flight blocks external loads and rewrites every word, so let it finish first
   task automatic settle();
      @(negedge clock_in);
      for (int i = 0; i < 40 && loading !== 1'b0; i++) @(negedge clock_in);
      tmo(loading !== 1'b0);
   endtask : settle
   // scenarios
   task automatic t_default();
      tick(24);
      @(negedge clock_in);
      for (int i = 0; i < NUM_CFG; i++)
         chk(live_cfg[i*CELL_W +: CELL_W], CFG_RESET_VAL);
      chk(32'(tof_rate), 32'(TOF_RATE_DEFAULT));
      chk(32'(measure_run), 32'h0000_0001);
      chk(32'(gp_mask[GP_SIX:GP_FIVE]), 32'h0000_0000);
   endtask : t_default
   task automatic t_bad_key();
      for (int i = 0; i < NUM_CFG; i++)
         hw(0, CFG_FIRST + 9'(i), 32'h5a00_0100 + 32'(i));
      hw(1, USM_PRC_CELL, 32'h0000_0000);
      hw(0, KEY_CELL, RELEASE_CODE ^ 32'h0000_0001);
      sysrst();
      for (int i = 0; i < NUM_CFG; i++)
         chk(live_cfg[i*CELL_W +: CELL_W], CFG_RESET_VAL);
   endtask : t_bad_key
   task automatic t_load();
      hw(0, FHL_CELL_A, 32'hc0de_0001);
      hw(0, FHL_CELL_B, 32'hc0de_0002);
      hw(0, FWCFG_CELL, 32'hc0de_0003);
      hw(0, AMP_MIN_ADDR >> 2, 32'hc0de_0004);
      hw(2, KEY_CELL, 32'h0000_0000);
      sysrst();
      for (int i = 0; i < NUM_CFG; i++)
         chk(live_cfg[i*CELL_W +: CELL_W], exp_word(i));
      chk(32'(tof_rate), 32'h0000_0014);
      chk(fhl_a, 32'hc0de_0001);
      chk(fhl_b, 32'hc0de_0002);
      chk(fw_cfg, 32'hc0de_0003);
      chk(amp_min, 32'hc0de_0004);
      hr(KEY_CELL, RELEASE_CODE);
      // a rate of one must leave the stored processing word as it was
      tick(1);
      tof_rate_req <= 8'h01;
      hw(1, USM_PRC_CELL, 32'h0000_0000);
      hr(USM_PRC_CELL, 32'h1400_2824);
   endtask : t_load
   task automatic t_wdog();
      tick(1);
      temp_cfg <= 1'b0;
      ext(2, 32'hdead_0002);
      wait_word(2, int'(3*WC));
      settle();
   endtask : t_wdog
   task automatic t_refresh();
      tick(1);
      kick_en <= 1'b1;
      ext(3, 32'hdead_0003);
      wait_word(3, int'(2*RC+20));
   endtask : t_refresh
   task automatic t_no_refresh();
      hw(0, CFG_FIRST, 32'h0000_0000);
      ext(4, 32'hdead_0004);
      tick(int'(2*RC+20));
      @(negedge clock_in);
      chk(live_cfg[4*CELL_W +: CELL_W], 32'hdead_0004);
   endtask : t_no_refresh
   task automatic t_temp();
      hw(0, CFG_FIRST, exp_word(0));
      tick(1);
      temp_cfg <= 1'b1;
      tick(3);
      @(negedge clock_in);
      chk(32'({pp_en, wd_en}), 32'h0000_0000);
      // the long idle before may have made a refresh due the moment cell 108 turned nonzero
      settle();
      ext(5, 32'hdead_0005);
      tick(int'(2*RC+20));
      @(negedge clock_in);
      chk(live_cfg[5*CELL_W +: CELL_W], 32'hdead_0005);
   endtask : t_temp
   // every cell known and only the reference cell nonzero: the xor then equals the reference
   task automatic t_cksum();
      for (int i = 0; i < 128; i++)
         hw(0, 9'(i), (i == int'(CKREF_DATA)) ? 32'h1234_5678 : 32'h0000_0000);
      tick(260);
      @(negedge clock_in);
      chk(cksum, 32'h1234_5678);
      chk(32'(cksum_ok), 32'h0000_0001);
   endtask : t_cksum
   // main sequence
   initial begin
      tick(20);
      rstn_in <= 1'b1;
      t_default();
      t_bad_key();
      t_load();
      t_wdog();
      t_refresh();
      t_no_refresh();
      t_temp();
      t_cksum();
      results();
   end
endmodule : tb_top
